// file: cmt_params.svh
`ifndef CMT_PARAMS_SVH
`define CMT_PARAMS_SVH
// register byte offsets
`define CMT_OFF_CTRL      12'h000
`define CMT_OFF_INST_SEL  12'h004
`define CMT_OFF_ENTRY_SEL 12'h008
`define CMT_OFF_VALUE     12'h00C
`define CMT_OFF_PRESET    12'h010
`define CMT_OFF_SAT       12'h014
`define CMT_OFF_WB_RED    12'h018
`define CMT_OFF_WB_BLUE   12'h01C
`define CMT_OFF_FORMAT    12'h020
// control register field positions
`define CMT_CTRL_PIPE_BIT 0
`define CMT_CTRL_CORR_BIT 1
`define CMT_CTRL_SAT_BIT  2
// coefficient format: signed fixed point, 1.0 = 16'h0400
`define CMT_COEF_ONE      16'sh0400
`define CMT_COEF_FRAC     10
`define CMT_SAT_RESET     16'h0400
`define CMT_WB_RESET      16'h0400
`define CMT_NUM_ENTRIES   12
`define CMT_NUM_PRESETS   8
`define CMT_PRESET_CUSTOM 3'h7
`define CMT_LATENCY       3
`endif

// file: cmt_pkg.sv
package cmt_pkg;
  typedef enum logic [0:0] {CMT_INST_CORR, CMT_INST_YUV} cmt_inst_e;
  typedef enum logic [1:0] {CMT_FMT_RGB, CMT_FMT_YUV, CMT_FMT_MONO, CMT_FMT_RAW} cmt_fmt_e;
  typedef logic signed [15:0] cmt_coef_t;
endpackage : cmt_pkg

// file: cmt_coef_mem.sv
`timescale 1ns/10ps
// small coefficient store, registered read port, plus flat view of all words
module cmt_coef_mem #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // write port
  input  wire logic                wr_en,
  input  wire logic [AW-1:0]       wr_addr,
  input  wire logic [15:0]         wr_data,
  // read port
  input  wire logic [AW-1:0]       rd_addr,
  output logic      [15:0]         rd_data,
  // all words, for the datapath
  output logic      [DEPTH*16-1:0] all_words
);
  logic [15:0] mem_q [DEPTH];

  // store, reset clears to zero so custom starts as a null matrix
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_word
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) mem_q[gi] <= 16'h0000;
        else if (wr_en && wr_addr == AW'(gi)) mem_q[gi] <= wr_data;
      end
      assign all_words[gi*16 +: 16] = mem_q[gi];
    end
  endgenerate

  // registered read data
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rd_data <= 16'h0000;
    else rd_data <= mem_q[rd_addr];
  end
endmodule : cmt_coef_mem

// file: cmt_top.sv
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`include "cmt_params.svh"
//------------------------------------------------------------
// color matrix transform
//------------------------------------------------------------
// Function
// - each output channel is a gain row times rgb plus its offset
// - two independent matrix instances: correction and luma chroma conversion
// - correction stage off when enable written 0, on when written 1, only while processing is already on
// - correction coefficients come from the selected illuminant preset
// - custom preset uses software-written entries picked by the entry selector
// - conversion stage runs after correction and after gamma
// - conversion active only for yuv pixel formats, no own enable
// - reading value returns the coefficient in use for the selected entry
// - saturation adjust applied only while its enable is 1
// - entry selector encodes nine gains then three offsets
// - writing the preset also loads red and blue balance ratios
// - enable is read-only while the conversion instance is selected
// - value field holds each coefficient as a fractional quantity
module cmt_top #(
  parameter int PW = 12
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rst_b,
  // apb slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // pixel in, raw rgb
  input  wire logic          pix_in_valid,
  input  wire logic [PW-1:0] pix_in_r,
  input  wire logic [PW-1:0] pix_in_g,
  input  wire logic [PW-1:0] pix_in_b,
  // gamma hook between stages
  output logic               gamma_out_valid,
  output logic [PW-1:0]      gamma_out_c0,
  output logic [PW-1:0]      gamma_out_c1,
  output logic [PW-1:0]      gamma_out_c2,
  input  wire logic          gamma_in_valid,
  input  wire logic [PW-1:0] gamma_in_c0,
  input  wire logic [PW-1:0] gamma_in_c1,
  input  wire logic [PW-1:0] gamma_in_c2,
  // pixel out
  output logic               pix_out_valid,
  output logic [PW-1:0]      pix_out_c0,
  output logic [PW-1:0]      pix_out_c1,
  output logic [PW-1:0]      pix_out_c2,
  // white balance ratios toward the balance stage
  output logic [15:0]        white_balance_red_ratio,
  output logic [15:0]        white_balance_blue_ratio
);
  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  logic        pipeline_processing_on_q, correction_stage_on_q, vividness_adjust_on_q;
  logic        transform_instance_select_q;
  logic [3:0]  coefficient_entry_select_q;
  logic [2:0]  illuminant_preset_select_q;
  logic [15:0] sat_level_q, wb_red_q, wb_blue_q;
  logic [1:0]  pix_format_q;
  logic [15:0] yuv_coef_q [`CMT_NUM_ENTRIES];

  // bus decode
  wire acc      = psel && penable;
  wire wr       = acc && pwrite;
  wire pipe_ok  = pipeline_processing_on_q;
  wire inst_yuv = transform_instance_select_q == cmt_pkg::CMT_INST_YUV;
  wire hit_ctrl = paddr == `CMT_OFF_CTRL;
  wire hit_isel = paddr == `CMT_OFF_INST_SEL;
  wire hit_esel = paddr == `CMT_OFF_ENTRY_SEL;
  wire hit_val  = paddr == `CMT_OFF_VALUE;
  wire hit_pre  = paddr == `CMT_OFF_PRESET;
  wire hit_sat  = paddr == `CMT_OFF_SAT;
  wire hit_wbr  = paddr == `CMT_OFF_WB_RED;
  wire hit_wbb  = paddr == `CMT_OFF_WB_BLUE;
  wire hit_fmt  = paddr == `CMT_OFF_FORMAT;
  wire hit_any  = hit_ctrl | hit_isel | hit_esel | hit_val | hit_pre | hit_sat | hit_wbr | hit_wbb | hit_fmt;
  // color controls other than ctrl/format/balance ratios refuse access while processing is off
  wire col_reg  = hit_isel | hit_esel | hit_val | hit_pre | hit_sat;
  wire refuse   = !hit_any || (col_reg && !pipe_ok);
  wire entry_ok = coefficient_entry_select_q < 4'(`CMT_NUM_ENTRIES);
  wire wr_ok    = wr && !refuse;
  wire custom   = illuminant_preset_select_q == `CMT_PRESET_CUSTOM;
  // custom entries write only on the correction instance with custom preset
  wire cust_we  = wr_ok && hit_val && !inst_yuv && custom && entry_ok;

  //------------------------------------------------------------
  // preset tables
  //------------------------------------------------------------
  // preset matrices: diagonal gain with mild per-illuminant tilt, zero offsets
  function automatic logic [15:0] preset_coef(input logic [2:0] p, input logic [3:0] e);
    logic [15:0] tilt;
    tilt = {9'h000, p, 4'h0};
    case (e)
      4'h0: preset_coef = 16'h0400 + tilt;
      4'h4: preset_coef = 16'h0400;
      4'h8: preset_coef = 16'h0400 - tilt;
      default: preset_coef = 16'h0000;
    endcase
  endfunction : preset_coef

  // balance ratios per preset; warmer light needs more blue gain
  function automatic logic [31:0] preset_wb(input logic [2:0] p);
    preset_wb = {16'h0400 + {10'h000, p, 3'h0}, 16'h0600 - {10'h000, p, 3'h0}};
  endfunction : preset_wb

  // fixed luma chroma conversion, offsets on chroma centre
  localparam logic [16*`CMT_NUM_ENTRIES-1:0] YUV_INIT = {
    16'h0800, 16'h0800, 16'h0000,
    16'hFFAD, 16'hFF53, 16'h0200, 16'h0200, 16'hFEAD, 16'hFF53,
    16'h0075, 16'h0259, 16'h0132};

  //------------------------------------------------------------
  // coefficient memory for the custom set
  //------------------------------------------------------------
  logic [15:0]  cust_rd;
  logic [255:0] cust_all;
  cmt_coef_mem #(.DEPTH(16), .AW(4)) u_mem (
    .clk       (clk),
    .rst_b     (rst_b),
    .wr_en     (cust_we),
    .wr_addr   (coefficient_entry_select_q),
    .wr_data   (pwdata[15:0]),
    .rd_addr   (coefficient_entry_select_q),
    .rd_data   (cust_rd),
    .all_words (cust_all)
  );

  // active coefficient per entry of each instance
  logic [15:0] corr_coef [`CMT_NUM_ENTRIES];
  genvar gi;
  generate
    for (gi = 0; gi < `CMT_NUM_ENTRIES; gi++) begin : g_coef
      assign corr_coef[gi]  = custom ? cust_all[gi*16 +: 16] : preset_coef(illuminant_preset_select_q, 4'(gi));
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) yuv_coef_q[gi] <= YUV_INIT[gi*16 +: 16];
        else yuv_coef_q[gi] <= yuv_coef_q[gi];
      end
    end
  endgenerate

  // readback value, custom path uses the registered memory port
  wire [15:0] rd_val  = !entry_ok ? 16'h0000 :
                        inst_yuv ? yuv_coef_q[coefficient_entry_select_q] :
                        custom ? cust_rd : corr_coef[coefficient_entry_select_q];
  wire [31:0] rd_ctrl = {29'h0, vividness_adjust_on_q, correction_stage_on_q, pipeline_processing_on_q};
  wire [31:0] rd_mux  = hit_ctrl ? rd_ctrl :
                        hit_isel ? {31'h0, transform_instance_select_q} :
                        hit_esel ? {28'h0, coefficient_entry_select_q} :
                        hit_val  ? {{16{rd_val[15]}}, rd_val} :
                        hit_pre  ? {29'h0, illuminant_preset_select_q} :
                        hit_sat  ? {16'h0, sat_level_q} :
                        hit_wbr  ? {16'h0, wb_red_q} :
                        hit_wbb  ? {16'h0, wb_blue_q} :
                        hit_fmt  ? {30'h0, pix_format_q} : 32'h0;

  //------------------------------------------------------------
  // apb: two wait states so memory readback settles
  //------------------------------------------------------------
  logic wait_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_q  <= 1'b0;
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      wait_q  <= acc && !wait_q && !pready;
      pready  <= acc && wait_q;
      prdata  <= (acc && wait_q && !pwrite && !refuse) ? rd_mux : 32'h0;
      pslverr <= acc && wait_q && refuse;
    end
  end
  wire commit = wr_ok && pready;

  // control writes; enable bit ignored while conversion instance selected
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pipeline_processing_on_q <= 1'b0;
      correction_stage_on_q    <= 1'b0;
      vividness_adjust_on_q    <= 1'b0;
    end else if (commit && hit_ctrl) begin
      pipeline_processing_on_q <= pwdata[`CMT_CTRL_PIPE_BIT];
      vividness_adjust_on_q    <= pipe_ok ? pwdata[`CMT_CTRL_SAT_BIT] : vividness_adjust_on_q;
      if (pipe_ok && !inst_yuv) correction_stage_on_q <= pwdata[`CMT_CTRL_CORR_BIT];
    end
  end

  // selectors and levels
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      transform_instance_select_q <= 1'b0;
      coefficient_entry_select_q  <= 4'h0;
      illuminant_preset_select_q  <= 3'h0;
      sat_level_q                 <= `CMT_SAT_RESET;
      pix_format_q                <= 2'h0;
    end else begin
      if (commit && hit_isel) transform_instance_select_q <= pwdata[0];
      if (commit && hit_esel) coefficient_entry_select_q <= pwdata[3:0];
      if (commit && hit_pre)  illuminant_preset_select_q <= pwdata[2:0];
      if (commit && hit_sat)  sat_level_q <= pwdata[15:0];
      if (commit && hit_fmt)  pix_format_q <= pwdata[1:0];
    end
  end

  // balance ratios: preset write loads both, direct writes override later
  wire [31:0] wb_new = preset_wb(pwdata[2:0]);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_red_q  <= `CMT_WB_RESET;
      wb_blue_q <= `CMT_WB_RESET;
    end else if (commit && hit_pre) begin
      wb_red_q  <= wb_new[31:16];
      wb_blue_q <= wb_new[15:0];
    end else begin
      if (commit && hit_wbr) wb_red_q <= pwdata[15:0];
      if (commit && hit_wbb) wb_blue_q <= pwdata[15:0];
    end
  end
  assign white_balance_red_ratio  = wb_red_q;
  assign white_balance_blue_ratio = wb_blue_q;

  //------------------------------------------------------------
  // datapath: matrix stage as a function, three register stages each
  //------------------------------------------------------------
  function automatic logic [PW-1:0] clamp(input logic signed [39:0] v);
    logic signed [39:0] s;
    s = v >>> `CMT_COEF_FRAC;
    if (s < 0) clamp = '0;
    else if (s > 40'sd0 + {1'b0, {PW{1'b1}}}) clamp = {PW{1'b1}};
    else clamp = s[PW-1:0];
  endfunction : clamp

  function automatic logic [PW-1:0] mrow(input logic [15:0] g0, g1, g2, off,
                                         input logic [PW-1:0] r, g, b);
    logic signed [39:0] acc;
    acc = $signed(g0) * $signed({1'b0, r}) + $signed(g1) * $signed({1'b0, g})
        + $signed(g2) * $signed({1'b0, b}) + ($signed(off) <<< `CMT_COEF_FRAC);
    mrow = clamp(acc);
  endfunction : mrow

  // correction stage: s1 matrix, s2 saturation, s3 hook register
  logic          c1_v, c2_v, y1_v, y2_v;
  logic [PW-1:0] c1 [3], c2 [3], y1 [3], y2 [3];
  logic          corr_on, yuv_on;
  assign corr_on = correction_stage_on_q;
  assign yuv_on  = pix_format_q == cmt_pkg::CMT_FMT_YUV;

  // saturation: mix channel with luma approximated as green
  function automatic logic [PW-1:0] sat(input logic [PW-1:0] c, l, input logic [15:0] k);
    sat = clamp($signed(k) * ($signed({1'b0, c}) - $signed({1'b0, l})) + ($signed({1'b0, l}) <<< `CMT_COEF_FRAC));
  endfunction : sat

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      c1_v <= 1'b0; c2_v <= 1'b0; gamma_out_valid <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        c1[i] <= '0; c2[i] <= '0;
      end
      gamma_out_c0 <= '0; gamma_out_c1 <= '0; gamma_out_c2 <= '0;
    end else begin
      c1_v <= pix_in_valid;
      for (int i = 0; i < 3; i++) begin
        c1[i] <= corr_on ? mrow(corr_coef[3*i], corr_coef[3*i+1], corr_coef[3*i+2], corr_coef[9+i],
                                pix_in_r, pix_in_g, pix_in_b)
                         : (i == 0 ? pix_in_r : i == 1 ? pix_in_g : pix_in_b);
        c2[i] <= vividness_adjust_on_q ? sat(c1[i], c1[1], sat_level_q) : c1[i];
      end
      c2_v <= c1_v;
      gamma_out_valid <= c2_v;
      gamma_out_c0 <= c2[0]; gamma_out_c1 <= c2[1]; gamma_out_c2 <= c2[2];
    end
  end

  // conversion stage fed back from gamma
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      y1_v <= 1'b0; y2_v <= 1'b0; pix_out_valid <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        y1[i] <= '0; y2[i] <= '0;
      end
      pix_out_c0 <= '0; pix_out_c1 <= '0; pix_out_c2 <= '0;
    end else begin
      y1_v <= gamma_in_valid;
      for (int i = 0; i < 3; i++) begin
        y1[i] <= yuv_on ? mrow(yuv_coef_q[3*i], yuv_coef_q[3*i+1], yuv_coef_q[3*i+2], yuv_coef_q[9+i],
                               gamma_in_c0, gamma_in_c1, gamma_in_c2)
                        : (i == 0 ? gamma_in_c0 : i == 1 ? gamma_in_c1 : gamma_in_c2);
        y2[i] <= y1[i];
      end
      y2_v <= y1_v;
      pix_out_valid <= y2_v;
      pix_out_c0 <= y2[0]; pix_out_c1 <= y2[1]; pix_out_c2 <= y2[2];
    end
  end
endmodule : cmt_top

// file: cmt_props.sv
`timescale 1ns/10ps
//------------------------------------------------------------
// port checker for the color matrix transform
//------------------------------------------------------------
module cmt_props #(
  parameter int PW = 12
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pixel handshakes
  input wire logic        pix_in_valid,
  input wire logic        gamma_out_valid,
  input wire logic        gamma_in_valid,
  input wire logic        pix_out_valid,
  // balance ratio
  input wire logic [15:0] white_balance_red_ratio
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // one setup cycle followed by the first access cycle
  sequence s_access;
    psel && !penable ##1 psel && penable;
  endsequence

  // the slave counts two access edges before pready stands, so it is sampled high on the third
  a_pready_wait: assert property (s_access |-> !pready ##1 !pready ##1 pready)
    else $error("pready not on third access edge");
  a_pready_lone: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_with: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_unmapped_err: assert property (pready && paddr > 12'h020 |-> pslverr)
    else $error("unmapped access not refused");
  a_corr_lat: assert property (pix_in_valid |-> ##3 gamma_out_valid)
    else $error("correction output late");
  a_corr_src: assert property (gamma_out_valid |-> $past(pix_in_valid, 3))
    else $error("correction output without input");
  a_conv_lat: assert property (gamma_in_valid |-> ##3 pix_out_valid)
    else $error("conversion output late");
  a_wb_cause: assert property ($changed(white_balance_red_ratio) |-> $past(pready && pwrite))
    else $error("ratio changed without a write");

  // main scenarios seen
  c_refused: cover property (pready && pslverr);
  c_burst: cover property (pix_in_valid ##1 pix_in_valid);
  c_wb_load: cover property ($changed(white_balance_red_ratio));
endmodule : cmt_props

bind cmt_top cmt_props #(.PW(PW)) cmt_props_inst (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pix_in_valid(pix_in_valid), .gamma_out_valid(gamma_out_valid), .gamma_in_valid(gamma_in_valid),
  .pix_out_valid(pix_out_valid), .white_balance_red_ratio(white_balance_red_ratio));

// file: cmt_gamma_model.sv
`timescale 1ns/10ps
// external gamma stage: identity curve, one cycle, keeps expectations exact
module cmt_gamma_model #(
  parameter int PW = 12
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          in_valid,
  input  wire logic [PW-1:0] in_c0,
  input  wire logic [PW-1:0] in_c1,
  input  wire logic [PW-1:0] in_c2,
  output logic               out_valid,
  output logic [PW-1:0]      out_c0,
  output logic [PW-1:0]      out_c1,
  output logic [PW-1:0]      out_c2
);
  // idle data is inverted each cycle so stale values never look valid
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      {out_c0, out_c1, out_c2} <= '0;
    end else begin
      out_valid <= in_valid;
      {out_c0, out_c1, out_c2} <= in_valid ? {in_c0, in_c1, in_c2} : ~{out_c0, out_c1, out_c2};
    end
  end
endmodule : cmt_gamma_model

// file: color_matrix_transform_test.sv
`timescale 1ns/10ps
`include "cmt_params.svh"
module color_matrix_transform_test;
  //------------------------------------------------------------
  // stimulus and wiring
  //------------------------------------------------------------
  logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000, pix_in_r = 12'h000, pix_in_g = 12'h000, pix_in_b = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, pix_in_valid = 1'b0, go_v, gi_v, pix_out_valid;
  logic [11:0] go0, go1, go2, gi0, gi1, gi2, po0, po1, po2;
  logic [15:0] wb_red, wb_blue, v, seed = 16'h005E;
  logic [35:0] expq[$];
  int          fails = 0, tests_run = 0;
  int          perm[3] = '{2, 0, 1};
  logic        cor = 1'b0, sat0 = 1'b0;

  always #5 clk = ~clk;

  cmt_top #(.PW(12)) cmt_top_inst (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pix_in_valid(pix_in_valid), .pix_in_r(pix_in_r), .pix_in_g(pix_in_g), .pix_in_b(pix_in_b),
    .gamma_out_valid(go_v), .gamma_out_c0(go0), .gamma_out_c1(go1), .gamma_out_c2(go2),
    .gamma_in_valid(gi_v), .gamma_in_c0(gi0), .gamma_in_c1(gi1), .gamma_in_c2(gi2),
    .pix_out_valid(pix_out_valid), .pix_out_c0(po0), .pix_out_c1(po1), .pix_out_c2(po2),
    .white_balance_red_ratio(wb_red), .white_balance_blue_ratio(wb_blue));

  cmt_gamma_model #(.PW(12)) cmt_gamma_model_inst (.clk(clk), .rst_b(rst_b), .in_valid(go_v), .in_c0(go0),
    .in_c1(go1), .in_c2(go2), .out_valid(gi_v), .out_c0(gi0), .out_c1(gi1), .out_c2(gi2));

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] want, input string what);
    tests_run++;
    if (got !== want) begin
      fails++;
      $display("BAD t=%0t %s got %h want %h", $time, what, got, want);
    end
  endtask : cmp_word

  task automatic cmp_pix(input logic [35:0] got, input logic [35:0] want);
    tests_run++;
    if (got !== want) begin
      fails++;
      $display("BAD t=%0t pixel got %h want %h", $time, got, want);
    end
  endtask : cmp_pix

  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd

  // permutation matrix keeps every product exact, so no rounding is guessed
  function automatic logic [35:0] expect_pix(input logic [11:0] r, input logic [11:0] g, input logic [11:0] b);
    logic [11:0] i[3];
    logic [11:0] o[3];
    i = '{r, g, b};
    for (int k = 0; k < 3; k++) o[k] = cor ? i[perm[k]] : i[k];
    if (sat0) o = '{o[1], o[1], o[1]};
    return {o[0], o[1], o[2]};
  endfunction : expect_pix

  // apb master: holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic send(input int n);
    logic [11:0] r, g, b;
    for (int k = 0; k < n; k++) begin
      r = 12'(rnd() >> 4);
      g = 12'(rnd() >> 4);
      b = 12'(rnd() >> 4);
      @(posedge clk);
      pix_in_valid <= 1'b1;
      {pix_in_r, pix_in_g, pix_in_b} <= {r, g, b};
      expq.push_back(expect_pix(r, g, b));
    end
    @(posedge clk);
    pix_in_valid <= 1'b0;
    {pix_in_r, pix_in_g, pix_in_b} <= 36'({rnd(), rnd(), rnd()});
    repeat (10) @(posedge clk);
    cmp_word(expq.size(), 0, "pixels lost");
    $display("test pixels done, %0d sent", n);
  endtask : send

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // output monitor, compares in arrival order
  always @(posedge clk) begin
    // only the uncheckable case (saturation on, correction model off) is skipped
    if (pix_out_valid === 1'b1 && (!sat0 || cor)) begin
      if (expq.size() == 0) cmp_word(1, 0, "unexpected pixel");
      else cmp_pix({po0, po1, po2}, expq.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up();
  end

  //------------------------------------------------------------
  // main sequence
  //------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    cmp_word({wb_red, wb_blue}, {`CMT_WB_RESET, `CMT_WB_RESET}, "wb reset");
    apb(1'b1, `CMT_OFF_INST_SEL, 32'h1);
    cmp_word(er, 1, "refused while off");
    apb(1'b0, 12'h0FC, 32'h0);
    cmp_word({er, rd[30:0]}, 32'h80000000, "unmapped read");
    apb(1'b1, `CMT_OFF_CTRL, 32'h1);
    send(6);
    apb(1'b1, `CMT_OFF_PRESET, `CMT_PRESET_CUSTOM);
    for (int k = 0; k < 12; k++) begin
      v = rnd();
      apb(1'b1, `CMT_OFF_ENTRY_SEL, k);
      apb(1'b1, `CMT_OFF_VALUE, {16'h0000, v});
      apb(1'b0, `CMT_OFF_VALUE, 32'h0);
      cmp_word(rd, {{16{v[15]}}, v}, "coefficient readback");
    end
    for (int k = 0; k < 12; k++) begin
      apb(1'b1, `CMT_OFF_ENTRY_SEL, k);
      apb(1'b1, `CMT_OFF_VALUE, (k < 9 && k % 3 == perm[k / 3]) ? 32'h0400 : 32'h0);
    end
    apb(1'b1, `CMT_OFF_CTRL, 32'h3);
    cor = 1'b1;
    send(6);
    apb(1'b1, `CMT_OFF_SAT, 32'h0);
    apb(1'b1, `CMT_OFF_CTRL, 32'h7);
    sat0 = 1'b1;
    send(4);
    apb(1'b1, `CMT_OFF_CTRL, 32'h3);
    sat0 = 1'b0;
    send(2);
    apb(1'b1, `CMT_OFF_INST_SEL, 32'h1);
    apb(1'b1, `CMT_OFF_CTRL, 32'h1);
    apb(1'b0, `CMT_OFF_CTRL, 32'h0);
    cmp_word(rd, 32'h3, "enable locked");
    apb(1'b1, `CMT_OFF_ENTRY_SEL, 32'h0);
    apb(1'b1, `CMT_OFF_VALUE, 32'h0123);
    apb(1'b1, `CMT_OFF_INST_SEL, 32'h0);
    apb(1'b0, `CMT_OFF_VALUE, 32'h0);
    cmp_word(rd, 32'h0, "instances independent");
    send(2);
    // yuv: a white pixel cannot leave chroma at full scale
    apb(1'b1, `CMT_OFF_FORMAT, 32'h1);
    sat0 = 1'b1;
    cor = 1'b0;
    @(posedge clk);
    pix_in_valid <= 1'b1;
    {pix_in_r, pix_in_g, pix_in_b} <= 36'hFFFFFFFFF;
    @(posedge clk);
    pix_in_valid <= 1'b0;
    do @(posedge clk); while (pix_out_valid !== 1'b1);
    cmp_word(po1 !== 12'hFFF, 1, "yuv applied");
    apb(1'b1, `CMT_OFF_FORMAT, 32'h0);
    sat0 = 1'b0;
    cor = 1'b1;
    apb(1'b1, `CMT_OFF_WB_RED, 32'h7FFF);
    apb(1'b0, `CMT_OFF_WB_RED, 32'h0);
    cmp_word({rd[15:0], wb_red}, 32'h7FFF7FFF, "wb overwrite");
    apb(1'b1, `CMT_OFF_PRESET, 32'h0);
    apb(1'b0, `CMT_OFF_PRESET, 32'h0);
    cmp_word(wb_red !== 16'h7FFF, 1, "preset loads wb");
    // preset zero is a plain diagonal of unit gains, so correction on must look like bypass
    cor = 1'b0;
    send(2);
    $display("test registers done");
    wrap_up();
  end
endmodule : color_matrix_transform_test
